// File: rtl/txrxq_core.sv
// Purpose: tx/rx command chaining queue with double-buffered status
// Assumes: protocol engine gives one-cycle done pulses on ref_clk_i
// Notes: non-chaining mode keeps a one-deep queue and live flags only
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - reception end sets inhibit; masked interrupt
// - queue rx page clears inhibit, selects page
// - long enabled: byte 2 zero means long
// - header bytes: source, dest, count layout
// - store packet in sender's layout
// - inhibit set only after complete good store or a cancel of the last page
// - reset to non-chaining; chain on config bit 6
// - two pending commands, two statuses per direction
// - edge flags set only by completions
// - first tx command clears ready, acked
// - second tx command stored with page
// - tx done sets edge flag, interrupt, acked
// - only ack tx clears tx edge, status held
// - second tx interrupt after ack, gap
// - acked flag buffered, never interrupts
// - second tx starts next token, posts later
// - tx mask gates only tx edge flag
// - cancel tx drops oldest pending only
// - rx done sets edge flag; ack clears
// - second rx interrupt held, with gap
// - second rx page takes next packet
// - rx mask gates edge; cancel oldest unstarted
// - success sets acked; ready set either way
module txrxq_core
  import txrxq_pkg::*;
#(
  parameter int GAP_CYC = TXRXQ_GAP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tx_token_i,
  input wire logic tx_done_i,
  input wire logic tx_ack_ok_i,
  output logic tx_start_o,
  output logic [2:0] tx_page_o,
  input wire logic rx_start_i,
  input wire logic rx_done_i,
  input wire logic rx_good_i,
  input wire logic [7:0] rx_cnt_byte_i,
  output logic rx_arm_o,
  output logic [2:0] rx_page_o,
  output logic rx_long_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration and mask registers
  logic [7:0] cfg_ff, nxt_cfg;
  logic [1:0] msk_ff, nxt_msk;
  logic chain;
  logic speed_boost_option;
  logic cmd_wr;
  logic [3:0] op;
  logic [2:0] pg;
  assign chain = cfg_ff[TXRXQ_CFG_CHAIN_BIT];
  assign speed_boost_option = cfg_ff[TXRXQ_CFG_SPEED_BIT];
  assign cmd_wr = reg_wr_i && (reg_addr_i == TXRXQ_OFF_CMD);
  assign op = reg_wdata_i[7:4];
  assign pg = reg_wdata_i[2:0];

  // config and mask writes; soft reset leaves them alone
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_msk = msk_ff;
    if (reg_wr_i && reg_addr_i == TXRXQ_OFF_CONFIG) begin
      nxt_cfg = reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == TXRXQ_OFF_MASK) begin
      nxt_msk = reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_ff <= TXRXQ_CFG_RST;
      msk_ff <= TXRXQ_MSK_RST;
    end else begin
      cfg_ff <= nxt_cfg;
      msk_ff <= nxt_msk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit queue: entry 0 is oldest; active marks entry 0 in flight
  txrxq_cmd_s txq_ff [2];
  txrxq_cmd_s nxt_txq [2];
  txrxq_stat_s txs_ff [2];
  txrxq_stat_s nxt_txs [2];
  logic tx_act_ff, nxt_tx_act;
  logic tx_ready_flag_ff, nxt_tx_ready_flag;
  logic tx_acked_live_ff, nxt_tx_acked_live;

  always_comb begin
    nxt_txq = txq_ff;
    nxt_txs = txs_ff;
    nxt_tx_act = tx_act_ff;
    nxt_tx_ready_flag = tx_ready_flag_ff;
    nxt_tx_acked_live = tx_acked_live_ff;
    // completion of the head entry
    if (tx_done_i && tx_act_ff) begin
      nxt_tx_act = 1'b0;
      nxt_txq[0] = txq_ff[1];
      nxt_txq[1] = '0;
      nxt_tx_acked_live = tx_ack_ok_i;
      nxt_tx_ready_flag = !txq_ff[1].vld;
      if (chain) begin
        // push result behind any unacknowledged one
        if (!txs_ff[0].vld) begin
          nxt_txs[0] = '{vld: 1'b1, ok: tx_ack_ok_i};
        end else begin
          nxt_txs[1] = '{vld: 1'b1, ok: tx_ack_ok_i};
        end
      end
    end else if (tx_token_i && txq_ff[0].vld && !tx_act_ff) begin
      nxt_tx_act = 1'b1;
    end
    // host commands; late in the process so an ack pops any new push
    if (cmd_wr && op == TXRXQ_OP_ACK_TX) begin
      nxt_txs[0] = nxt_txs[1];
      nxt_txs[1] = '0;
    end else if (cmd_wr && op == TXRXQ_OP_QUEUE_TX) begin
      if (!nxt_txq[0].vld) begin
        nxt_txq[0] = '{vld: 1'b1, page: pg};
        nxt_tx_ready_flag = 1'b0;
        nxt_tx_acked_live = 1'b0;
      end else if (chain && !nxt_txq[1].vld) begin
        nxt_txq[1] = '{vld: 1'b1, page: pg};
      end
    end else if (cmd_wr && op == TXRXQ_OP_CANCEL_TX && txq_ff[0].vld) begin
      // oldest only, and only before it starts; an in-flight send cannot be withdrawn
      // a head launched by this cycle's token is already on the wire
      if (!tx_act_ff && !tx_start_o) begin
        nxt_txq[0] = nxt_txq[1];
        nxt_txq[1] = '0;
        nxt_tx_ready_flag = !nxt_txq[1].vld && !txq_ff[1].vld;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst_i) begin
      txq_ff <= '{default: '0};
      txs_ff <= '{default: '0};
      tx_act_ff <= 1'b0;
      tx_ready_flag_ff <= 1'b1;
      tx_acked_live_ff <= 1'b0;
    end else begin
      txq_ff <= nxt_txq;
      txs_ff <= nxt_txs;
      tx_act_ff <= nxt_tx_act;
      tx_ready_flag_ff <= nxt_tx_ready_flag;
      tx_acked_live_ff <= nxt_tx_acked_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive queue: engine writes bytes straight into the armed page
  txrxq_cmd_s rxq_ff [2];
  txrxq_cmd_s nxt_rxq [2];
  txrxq_stat_s rxs_ff [2];
  txrxq_stat_s nxt_rxs [2];
  logic rx_busy_ff, nxt_rx_busy;
  logic receive_inhibit_flag_ff, nxt_receive_inhibit_flag;
  logic rx_long_ff, nxt_rx_long;

  always_comb begin
    nxt_rxq = rxq_ff;
    nxt_rxs = rxs_ff;
    nxt_rx_busy = rx_busy_ff;
    nxt_receive_inhibit_flag = receive_inhibit_flag_ff;
    nxt_rx_long = rx_long_ff;
    if (rx_start_i && rxq_ff[0].vld) begin
      nxt_rx_busy = 1'b1;
    end
    if (rx_done_i && rx_busy_ff) begin
      nxt_rx_busy = 1'b0;
      if (rx_good_i) begin
        // count byte zero marks a long frame when enabled
        nxt_rx_long = cfg_ff[TXRXQ_CFG_LONG_BIT] &&
                      (rx_cnt_byte_i == 8'h00);
        nxt_rxq[0] = rxq_ff[1];
        nxt_rxq[1] = '0;
        nxt_receive_inhibit_flag = !rxq_ff[1].vld;
        if (chain) begin
          if (!rxs_ff[0].vld) begin
            nxt_rxs[0] = '{vld: 1'b1, ok: 1'b1};
          end else begin
            nxt_rxs[1] = '{vld: 1'b1, ok: 1'b1};
          end
        end
      end
    end
    if (cmd_wr && op == TXRXQ_OP_ACK_RX) begin
      nxt_rxs[0] = nxt_rxs[1];
      nxt_rxs[1] = '0;
    end else if (cmd_wr && op == TXRXQ_OP_QUEUE_RX) begin
      if (!nxt_rxq[0].vld) begin
        nxt_rxq[0] = '{vld: 1'b1, page: pg};
        nxt_receive_inhibit_flag = 1'b0;
      end else if (chain && !nxt_rxq[1].vld) begin
        nxt_rxq[1] = '{vld: 1'b1, page: pg};
      end
    end else if (cmd_wr && op == TXRXQ_OP_CANCEL_RX && rxq_ff[0].vld) begin
      // a reception already under way cannot be withdrawn
      if (!rx_busy_ff && !rx_start_i) begin
        nxt_rxq[0] = rxq_ff[1];
        nxt_rxq[1] = '0;
        nxt_receive_inhibit_flag = !rxq_ff[1].vld;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst_i) begin
      rxq_ff <= '{default: '0};
      rxs_ff <= '{default: '0};
      rx_busy_ff <= 1'b0;
      receive_inhibit_flag_ff <= 1'b1;
      rx_long_ff <= 1'b0;
    end else begin
      rxq_ff <= nxt_rxq;
      rxs_ff <= nxt_rxs;
      rx_busy_ff <= nxt_rx_busy;
      receive_inhibit_flag_ff <= nxt_receive_inhibit_flag;
      rx_long_ff <= nxt_rx_long;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt gap timers: a popped-in second status waits out the gap
  logic [7:0] tx_gap_ff, nxt_tx_gap;
  logic [7:0] rx_gap_ff, nxt_rx_gap;
  logic tx_pop, rx_pop;
  logic tx_edge, rx_edge;
  logic [7:0] gap_len;
  assign gap_len = speed_boost_option ? 8'(GAP_CYC) : 8'h01;
  assign tx_pop = cmd_wr && op == TXRXQ_OP_ACK_TX;
  assign rx_pop = cmd_wr && op == TXRXQ_OP_ACK_RX;
  // edge flags hide during the gap so the line drops in between
  assign tx_edge = txs_ff[0].vld && (tx_gap_ff == 8'h00);
  assign rx_edge = rxs_ff[0].vld && (rx_gap_ff == 8'h00);

  // gap counters reload on every acknowledge
  always_comb begin
    nxt_tx_gap = (tx_gap_ff != 8'h00) ? tx_gap_ff - 8'h01 : 8'h00;
    nxt_rx_gap = (rx_gap_ff != 8'h00) ? rx_gap_ff - 8'h01 : 8'h00;
    if (tx_pop) begin
      nxt_tx_gap = gap_len;
    end
    if (rx_pop) begin
      nxt_rx_gap = gap_len;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst_i) begin
      tx_gap_ff <= 8'h00;
      rx_gap_ff <= 8'h00;
    end else begin
      tx_gap_ff <= nxt_tx_gap;
      rx_gap_ff <= nxt_rx_gap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output: chained mode gates edge flags, else live flags
  logic nxt_irq;
  always_comb begin
    if (chain) begin
      nxt_irq = (msk_ff[TXRXQ_MSK_TX] && tx_edge) ||
                (msk_ff[TXRXQ_MSK_RX] && rx_edge);
    end else begin
      nxt_irq = (msk_ff[TXRXQ_MSK_TX] && tx_ready_flag_ff) ||
                (msk_ff[TXRXQ_MSK_RX] && receive_inhibit_flag_ff);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status read: acked comes from the head status entry when chained
  logic [7:0] status;
  logic [7:0] nxt_rdata;
  always_comb begin
    status = 8'h00;
    status[TXRXQ_ST_TX_READY] = tx_ready_flag_ff;
    status[TXRXQ_ST_TX_ACKED] = chain ? (txs_ff[0].vld && txs_ff[0].ok)
                                      : tx_acked_live_ff;
    status[TXRXQ_ST_TX_EDGE] = tx_edge;
    status[TXRXQ_ST_RX_INH] = receive_inhibit_flag_ff;
    status[TXRXQ_ST_RX_EDGE] = rx_edge;
    status[TXRXQ_ST_RX_LONG] = rx_long_ff;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (!reg_rd_i) begin
      nxt_rdata = 8'h00;
    end else if (reg_addr_i == TXRXQ_OFF_STATUS) begin
      nxt_rdata = status;
    end else if (reg_addr_i == TXRXQ_OFF_CONFIG) begin
      nxt_rdata = cfg_ff;
    end else if (reg_addr_i == TXRXQ_OFF_MASK) begin
      nxt_rdata = {6'h00, msk_ff};
    end else if (reg_addr_i == TXRXQ_OFF_PAGES) begin
      nxt_rdata = {1'b0, rxq_ff[0].page, 1'b0, txq_ff[0].page};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // engine side: page selection; frames land unrearranged in the page
  always_comb begin
    tx_start_o = tx_token_i && txq_ff[0].vld && !tx_act_ff;
    tx_page_o = txq_ff[0].page;
    rx_arm_o = rxq_ff[0].vld;
    rx_page_o = rxq_ff[0].page;
    rx_long_o = rx_long_ff;
  end
endmodule : txrxq_core
`default_nettype wire

// File: rtl/txrxq_pkg.sv
// Purpose: shared constants and types for the tx/rx command chaining queue
// Assumes: one clock, register port with one-cycle read latency
// Notes: offsets are word indices on the plain register port
package txrxq_pkg;
  // register offsets
  localparam logic [3:0] TXRXQ_OFF_STATUS = 4'h0;
  localparam logic [3:0] TXRXQ_OFF_CMD = 4'h1;
  localparam logic [3:0] TXRXQ_OFF_CONFIG = 4'h2;
  localparam logic [3:0] TXRXQ_OFF_MASK = 4'h3;
  localparam logic [3:0] TXRXQ_OFF_PAGES = 4'h4;
  // configuration bit positions
  localparam int TXRXQ_CFG_CHAIN_BIT = 6;
  localparam int TXRXQ_CFG_LONG_BIT = 3;
  localparam int TXRXQ_CFG_SPEED_BIT = 0;
  // status bit positions
  localparam int TXRXQ_ST_TX_READY = 0;
  localparam int TXRXQ_ST_TX_ACKED = 1;
  localparam int TXRXQ_ST_TX_EDGE = 2;
  localparam int TXRXQ_ST_RX_INH = 3;
  localparam int TXRXQ_ST_RX_EDGE = 4;
  localparam int TXRXQ_ST_RX_LONG = 5;
  // mask bit positions
  localparam int TXRXQ_MSK_TX = 0;
  localparam int TXRXQ_MSK_RX = 1;
  // reset values
  localparam logic [7:0] TXRXQ_CFG_RST = 8'h00;
  localparam logic [1:0] TXRXQ_MSK_RST = 2'h0;
  // command opcodes in wdata[7:4], page in wdata[2:0]
  localparam logic [3:0] TXRXQ_OP_QUEUE_TX = 4'h1;
  localparam logic [3:0] TXRXQ_OP_QUEUE_RX = 4'h2;
  localparam logic [3:0] TXRXQ_OP_CANCEL_TX = 4'h3;
  localparam logic [3:0] TXRXQ_OP_CANCEL_RX = 4'h4;
  localparam logic [3:0] TXRXQ_OP_ACK_TX = 4'h5;
  localparam logic [3:0] TXRXQ_OP_ACK_RX = 4'h6;
  // interrupt gap: 200 ns least time, rounded up in cycles
  localparam int TXRXQ_CLK_MHZ = 125;
  localparam int TXRXQ_GAP_NS = 200;
  localparam int TXRXQ_GAP_CYC = (TXRXQ_GAP_NS * TXRXQ_CLK_MHZ + 999) / 1000;
  // packet header byte offsets within a page
  localparam logic [8:0] TXRXQ_BYTE_SRC = 9'h000;
  localparam logic [8:0] TXRXQ_BYTE_DST = 9'h001;
  localparam logic [8:0] TXRXQ_BYTE_CNT = 9'h002;
  localparam logic [8:0] TXRXQ_BYTE_LCNT = 9'h003;
  // one command queue entry
  typedef struct packed {
    logic vld;
    logic [2:0] page;
  } txrxq_cmd_s;
  // one completion status entry
  typedef struct packed {
    logic vld;
    logic ok;
  } txrxq_stat_s;
endpackage : txrxq_pkg

// File: test/txrxq_core_sva.sv
// Purpose: port checks on txrxq_core
// Assumes: bus and engine pulses as handed over
// Notes: config and mask are shadowed from bus writes
`timescale 1ns/1ns
`default_nettype none
module txrxq_core_sva
  import txrxq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic tx_token_i,
  input wire logic tx_start_o,
  input wire logic rx_done_i,
  input wire logic rx_good_i,
  input wire logic [7:0] rx_cnt_byte_i,
  input wire logic rx_arm_o,
  input wire logic [2:0] rx_page_o,
  input wire logic rx_long_o,
  input wire logic irq_o
);
  logic [7:0] cfg_ff;
  logic [1:0] msk_ff;
  logic [2:0] wpg;
  logic q_rx, lng, rxok;
  // shadow the modes, since the rules depend on them
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_ff <= TXRXQ_CFG_RST;
      msk_ff <= TXRXQ_MSK_RST;
    end else if (reg_wr_i && reg_addr_i == TXRXQ_OFF_CONFIG) begin
      cfg_ff <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == TXRXQ_OFF_MASK) begin
      msk_ff <= reg_wdata_i[1:0];
    end
  end
  // decoded events; soft clear excluded as it overrides them
  assign wpg = reg_wdata_i[2:0];
  assign q_rx = reg_wr_i && reg_addr_i == TXRXQ_OFF_CMD && !soft_rst_i
    && reg_wdata_i[7:4] == TXRXQ_OP_QUEUE_RX;
  assign lng = cfg_ff[TXRXQ_CFG_LONG_BIT] && rx_cnt_byte_i == 8'h00;
  assign rxok = rx_done_i && rx_good_i && rx_arm_o && !soft_rst_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero");
  chk_start_token: assert property (tx_start_o |-> tx_token_i)
    else $error("send without token");
  chk_arm_queue: assert property (q_rx && !rx_arm_o |=>
    rx_arm_o && rx_page_o == $past(wpg)) else $error("page not armed");
  chk_long_flag: assert property (rxok |=> rx_long_o == $past(lng))
    else $error("long flag wrong");
  chk_arm_drop: assert property (rxok && !reg_wr_i &&
    !cfg_ff[TXRXQ_CFG_CHAIN_BIT] |=> !rx_arm_o) else $error("arm kept");
  chk_bad_keep: assert property (rx_done_i && !rx_good_i &&
    rx_arm_o && !soft_rst_i |=> rx_arm_o) else $error("arm lost");
  chk_irq_mask: assert property (msk_ff == 2'h0 &&
    $past(msk_ff) == 2'h0 |-> !irq_o) else $error("masked irq");
  chk_irq_gap: assert property ($fell(irq_o) && cfg_ff[6] &&
    cfg_ff[0] && !soft_rst_i |-> !irq_o [*8]) else $error("irq gap short");
  cov_start: cover property (tx_start_o);
  cov_long: cover property (rxok && lng);
  cov_gap: cover property ($fell(irq_o) && cfg_ff[6]);
endmodule : txrxq_core_sva
bind txrxq_core txrxq_core_sva txrxq_core_sva_i (.*);
`default_nettype wire

// File: test/txrxq_core_tb_top.sv
// Purpose: self-checking bench for txrxq_core
// Assumes: engine stand-in drives the protocol side
// Notes: status is read after the interrupt gap runs out
`timescale 1ns/1ns
`default_nettype none
module txrxq_core_tb_top;
  import txrxq_pkg::*;
  logic ref_clk_i, rst_n_i, soft_rst_i, reg_wr_i, reg_rd_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, rx_cnt_byte_i, lf;
  logic tx_token_i, tx_done_i, tx_ack_ok_i, tx_start_o, rx_start_i;
  logic rx_done_i, rx_good_i, rx_arm_o, rx_long_o, irq_o;
  logic [2:0] tx_page_o, rx_page_o;
  logic [2:0] txq[$], rxq[$];
  bit txs[$], rxs[$];
  bit chn, lng, lst, akl;
  bit [1:0] mskm;
  int errors, checked, cyc;
  ////////////////////////////////
  txrxq_core txrxq_core_i (.*);
  txrxq_engine txrxq_engine_i (.clk_i(ref_clk_i), .start_i(tx_start_o),
    .page_i(tx_page_o), .arm_i(rx_arm_o), .tok_o(tx_token_i),
    .txd_o(tx_done_i), .ack_o(tx_ack_ok_i), .rxs_o(rx_start_i),
    .rxd_o(rx_done_i), .good_o(rx_good_i), .cnt_o(rx_cnt_byte_i));
  // clock, and a hang guard well above the roughly 1300-cycle run
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      results();
    end
  end
  ////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("compares %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // bus cycles; a gap cycle keeps each strobe a single pulse
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(reg_rdata_o, e);
    @(posedge ref_clk_i);
  endtask : rd
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction : rnd
  // reference status from the queues
  function automatic logic [7:0] st();
    logic [7:0] s;
    s = 8'h00;
    s[TXRXQ_ST_TX_READY] = txq.size() == 0;
    s[TXRXQ_ST_TX_ACKED] = chn ? txs.size() > 0 && txs[0] : akl;
    s[TXRXQ_ST_TX_EDGE] = chn && txs.size() > 0;
    s[TXRXQ_ST_RX_INH] = rxq.size() == 0;
    s[TXRXQ_ST_RX_EDGE] = chn && rxs.size() > 0;
    s[TXRXQ_ST_RX_LONG] = lst;
    return s;
  endfunction : st
  task automatic look();
    logic [7:0] s;
    logic q;
    repeat (30) @(posedge ref_clk_i);
    s = st();
    q = chn ? |(mskm & {s[4], s[2]}) : |(mskm & {s[3], s[0]});
    @(negedge ref_clk_i);
    chk({3'h0, rx_arm_o, rx_page_o, irq_o},
      {3'h0, rxq.size() > 0, rxq.size() > 0 ? rxq[0] : 3'h0, q});
    @(posedge ref_clk_i);
    rd(TXRXQ_OFF_STATUS, s);
  endtask : look
  task automatic cmd(input logic [3:0] op, input logic [7:0] d);
    int n;
    n = chn ? 2 : 1;
    wr(TXRXQ_OFF_CMD, {op, 1'b0, d[2:0]});
    case (op)
      TXRXQ_OP_QUEUE_TX: if (txq.size() < n) begin
        txq.push_back(d[2:0]);
        akl = 1'b0;
      end
      TXRXQ_OP_QUEUE_RX: if (rxq.size() < n) rxq.push_back(d[2:0]);
      TXRXQ_OP_CANCEL_TX: if (txq.size() > 0) void'(txq.pop_front());
      TXRXQ_OP_CANCEL_RX: if (rxq.size() > 0) void'(rxq.pop_front());
      TXRXQ_OP_ACK_TX: if (txs.size() > 0) void'(txs.pop_front());
      TXRXQ_OP_ACK_RX: if (rxs.size() > 0) void'(rxs.pop_front());
      default: ;
    endcase
  endtask : cmd
  task automatic tok(input bit ok);
    bit g;
    logic [2:0] pg;
    txrxq_engine_i.token(ok, 6, g, pg);
    chk({4'h0, g, pg}, {4'h0, txq.size() > 0, txq.size() > 0 ? txq[0] : 3'h0});
    if (txq.size() > 0) begin
      void'(txq.pop_front());
      akl = ok;
      if (chn) txs.push_back(ok);
    end
  endtask : tok
  task automatic rcv(input bit good, input logic [7:0] c);
    bit a;
    a = rxq.size() > 0;
    txrxq_engine_i.recv(good, c, 2);
    if (a && good) begin
      void'(rxq.pop_front());
      lst = lng && c == 8'h00;
      if (chn) rxs.push_back(1'b1);
    end
  endtask : rcv
  task automatic cfg(input logic [7:0] v);
    wr(TXRXQ_OFF_CONFIG, v);
    chn = v[TXRXQ_CFG_CHAIN_BIT];
    lng = v[TXRXQ_CFG_LONG_BIT];
  endtask : cfg
  task automatic msk(input logic [1:0] m);
    wr(TXRXQ_OFF_MASK, {6'h00, m});
    mskm = m;
  endtask : msk
  task automatic rst();
    rst_n_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    txq.delete();
    rxq.delete();
    txs.delete();
    rxs.delete();
    {chn, lng, lst, akl, mskm} = 6'h00;
  endtask : rst
  ////////////////////////////////
  initial begin
    {rst_n_i, soft_rst_i, reg_wr_i, reg_rd_i, reg_addr_i} = 8'h00;
    reg_wdata_i = 8'h00;
    lf = 8'h48;
    @(posedge ref_clk_i);
    rst();
    look();
    rd(TXRXQ_OFF_PAGES, 8'h00);
    rd(4'hF, 8'h00);
    msk(2'h3);
    rd(TXRXQ_OFF_MASK, 8'h03);
    cmd(TXRXQ_OP_QUEUE_RX, 8'h05);
    look();
    rcv(1'b0, 8'h10);
    look();
    rcv(1'b1, 8'h00);
    look();
    cmd(TXRXQ_OP_QUEUE_TX, 8'h02);
    look();
    tok(1'b1);
    cmd(TXRXQ_OP_QUEUE_TX, 8'h03);
    tok(1'b0);
    look();
    cfg(8'h49);
    rd(TXRXQ_OFF_CONFIG, 8'h49);
    for (int i = 0; i < 3; i++) begin
      msk(i == 1 ? 2'h2 : 2'h3);
      repeat (3) cmd(TXRXQ_OP_QUEUE_TX, rnd());
      if (i == 2) cmd(TXRXQ_OP_CANCEL_TX, 8'h00);
      tok(i[0]);
      look();
      tok(1'b1);
      look();
      repeat (2) begin
        cmd(TXRXQ_OP_ACK_TX, 8'h00);
        look();
      end
      repeat (3) cmd(TXRXQ_OP_QUEUE_RX, rnd());
      if (i == 1) cmd(TXRXQ_OP_CANCEL_RX, 8'h00);
      repeat (2) begin
        rcv(1'b1, i == 0 ? 8'h00 : rnd());
        look();
      end
      repeat (2) begin
        cmd(TXRXQ_OP_ACK_RX, 8'h00);
        look();
      end
    end
    // soft clear with work pending, then a second hard reset
    cmd(TXRXQ_OP_QUEUE_RX, 8'h06);
    rcv(1'b1, 8'h07);
    cmd(TXRXQ_OP_QUEUE_TX, 8'h01);
    soft_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_rst_i <= 1'b0;
    txq.delete();
    rxs.delete();
    akl = 1'b0;
    look();
    cmd(TXRXQ_OP_QUEUE_TX, 8'h04);
    rst();
    look();
    rd(TXRXQ_OFF_CONFIG, TXRXQ_CFG_RST);
    results();
  end
endmodule : txrxq_core_tb_top
`default_nettype wire

// File: test/txrxq_engine.sv
// Purpose: protocol engine stand-in facing txrxq_core
// Assumes: tasks are entered just after a rising edge
// Notes: released lines carry inverted data, never stale
`timescale 1ns/1ns
`default_nettype none
module txrxq_engine (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [2:0] page_i,
  input wire logic arm_i,
  output logic tok_o,
  output logic txd_o,
  output logic ack_o,
  output logic rxs_o,
  output logic rxd_o,
  output logic good_o,
  output logic [7:0] cnt_o
);
  // quiet lines from time zero
  initial begin
    {tok_o, txd_o, ack_o, rxs_o, rxd_o, good_o, cnt_o} = 14'h0000;
  end
  // one-cycle token; send only if the queue started a page
  task automatic token(input bit ok, input int slow, output bit got,
    output logic [2:0] pg);
    tok_o <= 1'b1;
    @(negedge clk_i);
    got = start_i;
    pg = page_i;
    @(posedge clk_i);
    tok_o <= 1'b0;
    if (got) begin
      repeat (slow) @(posedge clk_i);
      txd_o <= 1'b1;
      ack_o <= ok;
      @(posedge clk_i);
      txd_o <= 1'b0;
      ack_o <= ~ok;
    end
  endtask : token
  // a packet only lands while a page is armed
  task automatic recv(input bit good, input logic [7:0] cnt, input int slow);
    if (arm_i) begin
      rxs_o <= 1'b1;
      @(posedge clk_i);
      rxs_o <= 1'b0;
      repeat (slow) @(posedge clk_i);
      rxd_o <= 1'b1;
      good_o <= good;
      cnt_o <= cnt;
      @(posedge clk_i);
      rxd_o <= 1'b0;
      good_o <= ~good;
      cnt_o <= ~cnt;
    end
  endtask : recv
endmodule : txrxq_engine
`default_nettype wire
